// file: hdl/sync_serial_port_pkg.sv
// Shared constants and carrier types of the synchronous serial port.
// Assumes a single system clock; control inputs come from logic on that clock.
`default_nettype none

package sync_serial_port_pkg;

    // ==========================================================
    // Sizes and timing
    localparam int MAX_WIDTH  = 16;
    localparam int BAUD_WIDTH = 16;
    localparam int NUM_CS     = 4;
    localparam int CNT_WIDTH  = 5;
    localparam int PER_WIDTH  = 19;
    localparam int PRESCALE   = 2;
    localparam int PHASE_AFTER = 2;

    // ==========================================================
    // Error flag positions
    localparam int ERR_COUNT = 4;
    localparam int ERR_RX    = 0;
    localparam int ERR_PHASE = 1;
    localparam int ERR_BAUD  = 2;
    localparam int ERR_TX    = 3;

    // ==========================================================
    // Reset values
    localparam logic [BAUD_WIDTH-1:0] BAUD_RESET = 16'h0000;
    localparam logic [NUM_CS-1:0]     CS_IDLE    = 4'hF;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic                  port_enable_bit;
        logic                  master_select_bit;
        logic                  auto_reset_enable;
        logic [ERR_COUNT-1:0]  err_enable;
        logic [NUM_CS-1:0]     cs_enable_register;
        logic [BAUD_WIDTH-1:0] baud_reload_field;
    } ctrl_type;

    typedef struct packed {
        logic              clk_o;
        logic              clk_oe;
        logic              mosi_o;
        logic              mosi_oe;
        logic              miso_o;
        logic              miso_oe;
        logic [NUM_CS-1:0] chip_select_n;
    } pins_type;

    typedef struct packed {
        logic [ERR_COUNT-1:0]  err_flags;
        logic                  error_irq_request;
        logic                  tx_empty;
        logic                  rx_full;
        logic [MAX_WIDTH-1:0]  receive_buffer;
        logic [BAUD_WIDTH-1:0] baud_value;
    } status_type;

    typedef enum logic [3:0] {
        M_IDLE  = 4'h1,
        M_LEAD  = 4'h2,
        M_SHIFT = 4'h4,
        M_TRAIL = 4'h8
    } mstate_type;

endpackage

`default_nettype wire

// file: hdl/sync_serial_port.sv
// Synchronous serial port: master/slave shifter, chip selects, baud timer, error checks.
// Assumes serial pins are asynchronous; control/data ports are on the system clock.
// How it works
// - chip selects lead by one bit, trail by half bit
// - enable bit at 0 selects that chip select
// - transmitter also captures its own line input
// - empty flag; reload shifts on without gap
// - pin directions follow master select bit
// - dedicated 16-bit baud timer with reload
// - timer counts at clock/2 while enabled
// - read live count enabled, reload disabled
// - bit rate is clock/(2*(reload+1))
// - rx/phase always; tx/baud errors slave only
// - error sets flag, enabled one requests irq
// - flags sticky until cleared; request self-clears
// - overrun sets flag and overwrites buffer
// - phase error on change near latching edge
// - slave clock beyond double/half flags baud
// - baud error with auto reset reinitialises
// - slave unwritten buffer flags tx error
// - slave drives first bit on buffer load
`default_nettype none

module sync_serial_port #(
    parameter int unsigned DW = 16
) (
    input  wire logic                                   clock,
    input  wire logic                                   nrst,
    input  wire sync_serial_port_pkg::ctrl_type         ctrl,
    input  wire logic                                   tx_write,
    input  wire logic [sync_serial_port_pkg::MAX_WIDTH-1:0] tx_data,
    input  wire logic                                   rx_read,
    input  wire logic [sync_serial_port_pkg::ERR_COUNT-1:0] err_clear,
    input  wire logic                                   sclk_in,
    input  wire logic                                   mosi_in,
    input  wire logic                                   miso_in,
    output var  sync_serial_port_pkg::pins_type         pins,
    output var  sync_serial_port_pkg::status_type       status
);
    import sync_serial_port_pkg::*;

    typedef struct packed {
        mstate_type             st;
        logic [DW-1:0]          shift;
        logic [CNT_WIDTH-1:0]   bitcnt;
        logic [MAX_WIDTH-1:0]   tx_buf;
        logic                   tx_full;
        logic                   tx_fresh;
        logic [BAUD_WIDTH-1:0]  reload;
        logic [BAUD_WIDTH-1:0]  timer;
        logic                   pre;
        logic                   active;
        logic [2:0]             clk_sync;
        logic [2:0]             mosi_sync;
        logic [2:0]             miso_sync;
        logic                   chg_prev;
        logic [1:0]             after_cnt;
        logic [PER_WIDTH-1:0]   period;
        logic                   in_frame;
        pins_type               pins;
        status_type             status;
    } state_type;

    localparam logic [CNT_WIDTH-1:0] LAST_BIT = CNT_WIDTH'(DW);

    state_type q;
    state_type d;

    // ==========================================================
    // Helpers
    function automatic logic [DW-1:0] shift_in(input logic [DW-1:0] s, input logic b);
        shift_in = {s[DW-2:0], b};
    endfunction

    // ==========================================================
    // Next state
    logic                   half_evt;
    logic                   latch_evt;
    logic                   frame_done;
    logic                   rise;
    logic                   fall;
    logic                   din;
    logic                   chg;
    logic [ERR_COUNT-1:0]   err_set;
    logic [BAUD_WIDTH:0]    sum;
    logic [BAUD_WIDTH-1:0]  mid;
    logic [PER_WIDTH-1:0]   lo_lim;
    logic [PER_WIDTH-1:0]   hi_lim;
    logic                   master;

    always_comb begin
        d          = q;
        half_evt   = 1'b0;
        latch_evt  = 1'b0;
        frame_done = 1'b0;
        err_set    = '0;
        master     = ctrl.master_select_bit;

        d.clk_sync  = {q.clk_sync[1:0], sclk_in};
        d.mosi_sync = {q.mosi_sync[1:0], mosi_in};
        d.miso_sync = {q.miso_sync[1:0], miso_in};
        rise = q.clk_sync[1] & ~q.clk_sync[2];
        fall = ~q.clk_sync[1] & q.clk_sync[2];
        din  = master ? q.miso_sync[1] : q.mosi_sync[1];
        chg  = master ? (q.miso_sync[1] ^ q.miso_sync[2]) : (q.mosi_sync[1] ^ q.mosi_sync[2]);
        d.chg_prev = chg;

        sum    = {1'b0, q.reload} + 17'h00001;
        mid    = sum[BAUD_WIDTH:1];
        lo_lim = PER_WIDTH'(sum);
        hi_lim = PER_WIDTH'({sum, 2'b00});

        if (!ctrl.port_enable_bit) begin
            d.reload   = ctrl.baud_reload_field;
            d.timer    = ctrl.baud_reload_field;
            d.pre      = 1'b0;
            d.st       = M_IDLE;
            d.bitcnt   = '0;
            d.active   = 1'b0;
            d.in_frame = 1'b0;
            d.period   = '0;
            d.after_cnt = 2'h0;
            d.pins.clk_o = 1'b0;
        end else begin
            // Baud timer, half-bit events at underflow and midpoint
            d.pre = ~q.pre;
            if (q.pre) begin
                if (q.timer == 16'h0000) begin
                    d.timer  = q.reload;
                    half_evt = 1'b1;
                end else begin
                    d.timer = q.timer - 16'h0001;
                    if (q.timer == mid) begin
                        half_evt = 1'b1;
                    end
                end
            end

            if (master) begin
                d.in_frame = 1'b0;
                d.period   = '0;
                case (q.st)
                    M_IDLE: begin
                        if (q.tx_full) begin
                            d.shift   = q.tx_buf[DW-1:0];
                            d.tx_full = 1'b0;
                            d.st      = M_LEAD;
                        end
                    end
                    M_LEAD: begin
                        // Select on one half-bit event, first bit exactly one half bit later
                        if (half_evt && !q.active) begin
                            d.active = 1'b1;
                        end else if (half_evt) begin
                            d.pins.mosi_o = q.shift[DW-1];
                            d.st          = M_SHIFT;
                        end
                    end
                    M_SHIFT: begin
                        if (half_evt && !q.pins.clk_o) begin
                            d.pins.clk_o = 1'b1;
                            d.shift      = shift_in(q.shift, din);
                            d.bitcnt     = q.bitcnt + 5'h01;
                            latch_evt    = 1'b1;
                        end else if (half_evt) begin
                            d.pins.clk_o = 1'b0;
                            if (q.bitcnt == LAST_BIT) begin
                                frame_done = 1'b1;
                                d.bitcnt   = '0;
                                if (q.tx_full) begin
                                    d.shift       = q.tx_buf[DW-1:0];
                                    d.pins.mosi_o = q.tx_buf[DW-1];
                                    d.tx_full     = 1'b0;
                                end else begin
                                    d.st = M_TRAIL;
                                end
                            end else begin
                                d.pins.mosi_o = q.shift[DW-1];
                            end
                        end
                    end
                    M_TRAIL: begin
                        if (half_evt) begin
                            d.active = 1'b0;
                            d.st     = M_IDLE;
                        end
                    end
                    default: begin
                        d.st = M_IDLE;
                    end
                endcase
            end else begin
                d.st     = M_IDLE;
                d.active = 1'b0;
                d.pins.clk_o = 1'b0;
                if (q.bitcnt == 5'h00 && q.tx_full && !rise) begin
                    d.shift       = q.tx_buf[DW-1:0];
                    d.pins.miso_o = q.tx_buf[DW-1];
                    d.tx_full     = 1'b0;
                end
                if (q.in_frame && q.period != {PER_WIDTH{1'b1}}) begin
                    d.period = q.period + 19'h00001;
                end
                if (rise) begin
                    latch_evt = 1'b1;
                    d.shift   = shift_in(q.shift, din);
                    d.bitcnt  = q.bitcnt + 5'h01;
                    d.period  = '0;
                    d.in_frame = 1'b1;
                    if (q.bitcnt == 5'h00) begin
                        err_set[ERR_TX] = ~q.tx_fresh;
                        d.tx_fresh      = 1'b0;
                    end else if (q.period < lo_lim) begin
                        err_set[ERR_BAUD] = 1'b1;
                    end
                    if (q.bitcnt == LAST_BIT - 5'h01) begin
                        frame_done = 1'b1;
                        d.bitcnt   = '0;
                        d.in_frame = 1'b0;
                        if (q.tx_full) begin
                            d.shift       = q.tx_buf[DW-1:0];
                            d.pins.miso_o = q.tx_buf[DW-1];
                            d.tx_full     = 1'b0;
                        end
                    end
                end else if (fall && q.bitcnt != 5'h00) begin
                    d.pins.miso_o = q.shift[DW-1];
                end else if (fall) begin
                    if (!(q.tx_full)) begin
                        d.pins.miso_o = q.shift[DW-1];
                    end
                end
                if (q.in_frame && q.period > hi_lim) begin
                    err_set[ERR_BAUD] = 1'b1;
                end
                if (err_set[ERR_BAUD]) begin
                    d.in_frame = 1'b0;
                    d.period   = '0;
                    if (ctrl.auto_reset_enable) begin
                        d.bitcnt = '0;
                        d.shift  = '0;
                        frame_done = 1'b0;
                    end
                end
            end

            // Data change one sample before to two samples after latching, three after for master
            if (latch_evt) begin
                err_set[ERR_PHASE] = chg | q.chg_prev;
                // Master latch leads its own clock pin by one cycle, the pin being registered
                d.after_cnt        = master ? 2'(PHASE_AFTER + 1) : 2'(PHASE_AFTER);
            end else if (q.after_cnt != 2'h0) begin
                d.after_cnt = q.after_cnt - 2'h1;
                if (chg) begin
                    err_set[ERR_PHASE] = 1'b1;
                end
            end
        end

        // Receive buffer with overrun
        if (rx_read) begin
            d.status.rx_full = 1'b0;
        end
        if (frame_done) begin
            // Master ends on the falling edge with all bits in; slave ends on the last latch
            d.status.receive_buffer = MAX_WIDTH'(master ? q.shift : shift_in(q.shift, din));
            err_set[ERR_RX]         = q.status.rx_full & ~rx_read;
            d.status.rx_full        = 1'b1;
        end

        // Transmit buffer write wins over a same-cycle load
        if (tx_write) begin
            d.tx_buf   = tx_data;
            d.tx_full  = 1'b1;
            d.tx_fresh = 1'b1;
        end

        if (master) begin
            err_set[ERR_TX]   = 1'b0;
            err_set[ERR_BAUD] = 1'b0;
        end
        d.status.err_flags         = (q.status.err_flags & ~err_clear) | err_set;
        d.status.error_irq_request = |(err_set & ctrl.err_enable);
        d.status.tx_empty          = ~d.tx_full;
        d.status.baud_value        = ctrl.port_enable_bit ? d.timer : d.reload;

        d.pins.clk_oe  = ctrl.port_enable_bit & master;
        d.pins.mosi_oe = ctrl.port_enable_bit & master;
        d.pins.miso_oe = ctrl.port_enable_bit & ~master;
        for (int i = 0; i < NUM_CS; i++) begin
            d.pins.chip_select_n[i] = ~(d.active & ~ctrl.cs_enable_register[i]);
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q                        <= '0;
            q.st                     <= M_IDLE;
            q.reload                 <= BAUD_RESET;
            q.timer                  <= BAUD_RESET;
            q.pins.chip_select_n     <= CS_IDLE;
            q.status.tx_empty        <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign pins   = q.pins;
    assign status = q.status;

endmodule

`default_nettype wire

// file: testbench/sync_serial_port_props.sv
// Port-level checks of the synchronous serial port.
// Assumes ctrl fields only change between frames.
`default_nettype none
module sync_serial_port_props #(
    parameter int unsigned DW = 16
) (
    input wire logic                                     clock,
    input wire logic                                     nrst,
    input wire sync_serial_port_pkg::ctrl_type           ctrl,
    input wire logic                                     tx_write,
    input wire logic [sync_serial_port_pkg::MAX_WIDTH-1:0] tx_data,
    input wire logic [sync_serial_port_pkg::ERR_COUNT-1:0] err_clear,
    input wire logic                                     sclk_in,
    input wire sync_serial_port_pkg::pins_type           pins,
    input wire sync_serial_port_pkg::status_type         status
);
    timeunit 1ns;
    timeprecision 1ps;
    import sync_serial_port_pkg::*;
    // ==========================================
    // Helper counters
    logic [PER_WIDTH-1:0] gap_q;
    logic [PER_WIDTH-1:0] lead_q;
    logic                 frame_q;
    logic                 clk_q;
    logic                 rise;
    assign rise = pins.clk_o & ~clk_q;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            gap_q   <= '0;
            lead_q  <= '0;
            frame_q <= 1'b0;
            clk_q   <= 1'b0;
        end else begin
            clk_q   <= pins.clk_o;
            gap_q   <= rise ? '0 : gap_q + 1'b1;
            lead_q  <= (&pins.chip_select_n) ? '0 : lead_q + 1'b1;
            frame_q <= (&pins.chip_select_n) ? 1'b0 : (rise | frame_q);
        end
    end
    // ==========================================
    // Properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence slave_load_s;
        !ctrl.master_select_bit && ctrl.port_enable_bit && tx_write && !sclk_in;
    endsequence
    sequence first_rise_s;
        rise && !frame_q;
    endsequence
    cs_mask_a: assert property ((pins.chip_select_n & ctrl.cs_enable_register) == ctrl.cs_enable_register)
        else $error("masked chip select asserted");
    pin_dir_a: assert property (ctrl.port_enable_bit && $past(ctrl.port_enable_bit) |->
        pins.clk_oe == ctrl.master_select_bit && pins.mosi_oe == ctrl.master_select_bit)
        else $error("pin direction wrong for mode");
    baud_hold_a: assert property (!ctrl.port_enable_bit [*2] |->
        status.baud_value == $past(ctrl.baud_reload_field)) else $error("reload not shown while off");
    timer_step_a: assert property (ctrl.port_enable_bit [*3] ##0 $changed(status.baud_value) |->
        status.baud_value == $past(status.baud_value) - 16'h0001 || $past(status.baud_value) == 16'h0000)
        else $error("timer did not count down");
    step_pace_a: assert property (ctrl.port_enable_bit [*3] ##0 $changed(status.baud_value) |=>
        $stable(status.baud_value) || !ctrl.port_enable_bit) else $error("timer faster than clock/2");
    irq_cause_a: assert property (status.error_irq_request |-> |status.err_flags)
        else $error("request without error flag");
    irq_new_a: assert property (|(status.err_flags & ~$past(status.err_flags) & ctrl.err_enable) |->
        status.error_irq_request || $past(status.error_irq_request)) else $error("enabled error gave no request");
    flag_hold_a: assert property (($past(status.err_flags) & ~status.err_flags & ~$past(err_clear)) == 4'h0)
        else $error("error flag dropped without clear");
    slave_err_a: assert property (ctrl.master_select_bit |->
        !$rose(status.err_flags[ERR_TX]) && !$rose(status.err_flags[ERR_BAUD])) else $error("slave error in master");
    cs_lead_a: assert property (first_rise_s |->
        lead_q == PER_WIDTH'(2 * ctrl.baud_reload_field + 2)) else $error("chip select lead wrong");
    bit_rate_a: assert property (rise && frame_q |-> gap_q == PER_WIDTH'(2 * ctrl.baud_reload_field + 1))
        else $error("bit period wrong");
    slave_first_a: assert property (slave_load_s |-> ##2 pins.miso_o == $past(tx_data[DW-1], 2))
        else $error("slave first bit late");
endmodule

bind sync_serial_port sync_serial_port_props #(.DW(DW)) u_props (.clock(clock), .nrst(nrst), .ctrl(ctrl),
    .tx_write(tx_write), .tx_data(tx_data), .err_clear(err_clear), .sclk_in(sclk_in), .pins(pins), .status(status));
`default_nettype wire

// file: testbench/serial_slave_model.sv
// Behavioural serial slave on the far side of a master port.
// Assumes clock idles low, latch on rising, shift on falling.
`default_nettype none
module serial_slave_model #(
    parameter int DW = 8
) (
    input  wire logic          clk,
    input  wire logic          sel_n,
    input  wire logic          din,
    input  wire logic          late,
    input  wire logic [DW-1:0] word,
    output var  logic          dout,
    output var  logic [15:0]   got
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DW-1:0] sh;
    logic          sel_d;
    logic          clk_d;
    // One process drives every output of the model
    initial begin
        dout  = 1'b0;
        got   = '0;
        sh    = '0;
        sel_d = 1'b1;
        clk_d = 1'b0;
        forever begin
            @(sel_n or clk);
            if (sel_d && !sel_n) begin
                sh   = word;
                dout = word[DW-1];
            end else if (!sel_d && sel_n) begin
                dout = ~dout;
            end
            if (!clk_d && clk) begin
                got = {got[14:0], din};
                if (late) dout = ~dout;
            end else if (clk_d && !clk && !sel_n) begin
                sh   = {sh[DW-2:0], sh[DW-1]};
                dout = sh[DW-1];
            end
            sel_d = sel_n;
            clk_d = clk;
        end
    end
endmodule
`default_nettype wire

// file: testbench/tb_sync_serial_port.sv
// Self-checking bench of the synchronous serial port.
// Assumes the slave model and checker files are compiled first.
`default_nettype none
`define CHK(nm, ex, sn) begin cmp_count++; if ((sn) !== (ex)) begin bad_count++; \
    $display("ERROR %s exp %0h got %0h", nm, ex, sn); end end
module tb_sync_serial_port;
    timeunit 1ns;
    timeprecision 1ps;
    import sync_serial_port_pkg::*;
    localparam int DW = 8;
    typedef struct {logic [3:0] cs; logic [7:0] tx; logic [7:0] sw;} row_type;
    row_type      rows [3] = '{'{4'hE, 8'hA5, 8'h3C}, '{4'h5, 8'h01, 8'hFE}, '{4'h0, 8'h80, 8'h7F}};
    logic         clock = 1'b0, nrst = 1'b0, tx_write = 1'b0, rx_read = 1'b0;
    logic         sclk_in = 1'b0, mosi_in = 1'b0, late = 1'b0, half = 1'b0, slv_miso, miso_in;
    logic [15:0]  tx_data = '0, got;
    logic [3:0]   err_clear = '0, cs_and;
    logic [7:0]   word = '0, sv;
    ctrl_type     ctrl = '{1'b0, 1'b1, 1'b1, 4'hF, 4'hE, 16'h0005};
    pins_type     pins;
    status_type   status;
    int           bad_count = 0, cmp_count = 0, cs_rel = 0, rel_base = 0;
    assign miso_in = half ? pins.mosi_o : slv_miso;
    always #5 clock = ~clock;
    always @(posedge clock) cs_and <= tx_write ? 4'hF : (cs_and & pins.chip_select_n);
    always @(posedge pins.chip_select_n[0]) cs_rel++;
    sync_serial_port #(.DW(DW)) uut (.clock(clock), .nrst(nrst), .ctrl(ctrl), .tx_write(tx_write),
        .tx_data(tx_data), .rx_read(rx_read), .err_clear(err_clear), .sclk_in(sclk_in),
        .mosi_in(mosi_in), .miso_in(miso_in), .pins(pins), .status(status));
    serial_slave_model #(.DW(DW)) peer (.clk(pins.clk_o), .sel_n(&pins.chip_select_n), .din(pins.mosi_o),
        .late(late), .word(word), .dout(slv_miso), .got(got));
    task automatic step(input int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic send(input logic [7:0] d);
        tx_data  = {8'h00, d};
        tx_write = 1'b1;
        step();
        tx_write = 1'b0;
    endtask
    task automatic wait_rx(input bit rd);
        for (int n = 0; n < 1000 && status.rx_full !== 1'b1; n++) step();
        rx_read = rd;
        step();
        rx_read = 1'b0;
    endtask
    task automatic wait_flag(input int k);
        for (int n = 0; n < 1000 && status.err_flags[k] !== 1'b1; n++) step();
    endtask
    task automatic sframe(input logic [7:0] d, input int hp);
        for (int i = DW - 1; i >= 0; i--) begin
            mosi_in = d[i];
            step(hp);
            sv = {sv[6:0], pins.miso_o};
            sclk_in = 1'b1;
            step(hp);
            sclk_in = 1'b0;
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #500000;
        bad_count++;
        finish_test();
    end
    initial begin
        step(16);
        `CHK("cs_reset", 4'hF, pins.chip_select_n)
        `CHK("empty_reset", 1'b1, status.tx_empty)
        nrst = 1'b1;
        step(2);
        `CHK("baud_off", 16'h0005, status.baud_value)
        ctrl.port_enable_bit = 1'b1;
        for (int i = 0; i < 3; i++) begin
            ctrl.cs_enable_register = rows[i].cs;
            word = rows[i].sw;
            send(rows[i].tx);
            wait_rx(1);
            `CHK("rx_word", {8'h00, rows[i].sw}, status.receive_buffer)
            `CHK("peer_got", rows[i].tx, got[7:0])
            `CHK("cs_seen", rows[i].cs, cs_and)
            step(20);
            `CHK("cs_idle", 4'hF, pins.chip_select_n)
            $display("row %0d done", i);
        end
        `CHK("no_errors", 4'h0, status.err_flags)
        ctrl.cs_enable_register = 4'hE;
        rel_base = cs_rel;
        send(8'hC3);
        step(3);
        send(8'h5A);
        step();
        `CHK("buf_full", 1'b0, status.tx_empty)
        wait_rx(1);
        wait_rx(1);
        step(20);
        `CHK("chain", 16'hC35A, got)
        `CHK("cs_once", 1, cs_rel - rel_base)
        half = 1'b1;
        send(8'h96);
        wait_rx(1);
        `CHK("echo", 16'h0096, status.receive_buffer)
        half = 1'b0;
        $display("chain and echo done");
        word = 8'h22;
        send(8'h11);
        wait_rx(0);
        word = 8'h44;
        send(8'h12);
        wait_flag(ERR_RX);
        `CHK("overrun", 1'b1, status.err_flags[ERR_RX])
        `CHK("overwrite", 16'h0044, status.receive_buffer)
        err_clear = 4'h1;
        step();
        err_clear = 4'h0;
        wait_rx(1);
        `CHK("rx_cleared", 1'b0, status.err_flags[ERR_RX])
        late = 1'b1;
        send(8'h33);
        wait_flag(ERR_PHASE);
        late = 1'b0;
        wait_rx(1);
        `CHK("phase", 1'b1, status.err_flags[ERR_PHASE])
        $display("master errors done");
        ctrl.port_enable_bit = 1'b0;
        err_clear = 4'hF;
        step(2);
        err_clear = 4'h0;
        ctrl.master_select_bit = 1'b0;
        ctrl.port_enable_bit = 1'b1;
        step(2);
        send(8'h69);
        step(2);
        sframe(8'hB2, 6);
        wait_rx(1);
        `CHK("slave_rx", 16'h00B2, status.receive_buffer)
        `CHK("slave_tx", 8'h69, sv)
        sframe(8'h0F, 6);
        wait_rx(1);
        `CHK("underrun", 1'b1, status.err_flags[ERR_TX])
        `CHK("stale_out", 8'hB2, sv)
        sframe(8'hFF, 2);
        wait_flag(ERR_BAUD);
        `CHK("baud_err", 1'b1, status.err_flags[ERR_BAUD])
        rx_read = 1'b1;
        step();
        rx_read = 1'b0;
        send(8'h5C);
        step(2);
        sframe(8'hA1, 6);
        wait_rx(1);
        `CHK("after_reinit", 16'h00A1, status.receive_buffer)
        $display("slave tests done");
        finish_test();
    end
endmodule
`default_nettype wire
